// *** inc/mdc_map.svh ***
// register offsets, field positions and reset values of the main-domain control bank
//
// Operation
// - set spi clock-count error flag when a frame has not exactly 32 clocks.
// - set spi access violation on wrong access, init-only write in normal, unknown address.
// - set spi crc error flag when a received spi frame checksum mismatches.
// - set i2c crc error flag when a received i2c transfer checksum mismatches.
// - set i2c access violation on wrong access, init-only write in normal, unknown address.
// - error flags clear on reset and on writing one; writing zero keeps them.
// - summary error bit is OR of all comm flags and fail-safe comm error.
// - read-only bit shows live pll lock state.
// - read-only bit shows pll source: zero internal, one external input.
// - writing one to ext input disable drops external input selection; zero does nothing.
// - normal-state bit reads one only while main state machine is in normal.
// - wake1 and wake2 disable bits block wake-up when one; readable and writable.
// - writing one to standby request sends device to standby; zero does nothing.
// - pull-down disable bit forces pre-regulator pull-down off, else logic controls it.
// - writing one to a regulator disable request switches that regulator off.
// - writing one to an enable request switches regulator on unless its disable bit is also one; zero changes nothing.
// - two-bit boost slew field: slow, medium, fast, ultra fast.
// - tsd reaction zero shuts regulator only; one also goes to deep fail-safe.
// - pre-regulator low-side drive two-bit field, reset value 11.
// - pre-regulator high-side drive two-bit field, reset value from otp.
// - divider ratio bit selects analog mux divider, low or high ratio.
// - clock register field order fixed, all fields reset to zero.
// - external input divided by one when fin_divider zero, by six when one.
// - writing one to ext input select request asks for external pll input.
// - normal-state bit resets to one, other mode bits reset to zero.
`ifndef MDC_MAP_SVH
`define MDC_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MDC_ADDR_FLAGS   3'h0
`define MDC_ADDR_MODE    3'h1
`define MDC_ADDR_REGREQ  3'h2
`define MDC_ADDR_TSDSLEW 3'h3
`define MDC_ADDR_MUXSEL  3'h4
`define MDC_ADDR_CLOCK   3'h5

// ----------------------------------------
// flag register fields
// ----------------------------------------
`define MDC_FLG_SUMMARY   15
`define MDC_FLG_SPI_CLK   4
`define MDC_FLG_SPI_VIOL  3
`define MDC_FLG_SPI_CRC   2
`define MDC_FLG_I2C_CRC   1
`define MDC_FLG_I2C_VIOL  0
`define MDC_SPI_CLOCKS    6'h20

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MDC_MODE_PLL_LOCK 8
`define MDC_MODE_EXT_ACT  7
`define MDC_MODE_EXT_DIS  6
`define MDC_MODE_NORMAL   5
`define MDC_MODE_WAKE2    2
`define MDC_MODE_WAKE1    1
`define MDC_MODE_STBY     0

// ----------------------------------------
// regulator request, tsd/slew, analog mux, clock fields
// ----------------------------------------
`define MDC_REQ_PD_DIS    15
`define MDC_REQ_OFF_MSB   14
`define MDC_REQ_OFF_LSB   8
`define MDC_REQ_ON_MSB    6
`define MDC_REQ_ON_LSB    0
`define MDC_TS_SLEW_MSB   15
`define MDC_TS_SLEW_LSB   14
`define MDC_TS_REACT_MSB  13
`define MDC_TS_REACT_LSB  8
`define MDC_TS_LS_MSB     4
`define MDC_TS_LS_LSB     3
`define MDC_TS_HS_MSB     1
`define MDC_TS_HS_LSB     0
`define MDC_LS_DRIVE_RST  2'h3
`define MDC_MUX_RATIO     5
`define MDC_CLK_EXT_SEL   6
`define MDC_FIN_EDGE_LAST 2'h2

`endif

// *** inc/mdc_pkg.sv ***
// types shared by the main-domain control bank
package mdc_pkg;
    typedef enum logic {MDC_SRC_SPI, MDC_SRC_I2C} mdc_src_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        mdc_src_t    src;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } mdc_access_t;

    typedef struct packed {
        logic [6:0] on;
        logic [6:0] off;
    } mdc_reg_req_t;

    typedef struct packed {
        logic       mod_range;
        logic [3:0] out_mux;
        logic [2:0] out_phase;
        logic       out_src;
        logic       fin_divider;
        logic       modulation_enable;
        logic [3:0] tune;
    } mdc_clock_cfg_t;
endpackage

// *** src/mdc_regs.sv ***
// main-domain control and status register bank
`timescale 1ns/100ps
`include "mdc_map.svh"

module mdc_regs (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire mdc_pkg::mdc_access_t   acc,
    input  wire logic                   spi_clk_err_in,
    input  wire logic [5:0]             spi_clk_count,
    input  wire logic                   spi_frame_end,
    input  wire logic                   spi_crc_err_in,
    input  wire logic                   i2c_crc_err_in,
    input  wire logic                   spi_wrong_access_in,
    input  wire logic                   i2c_wrong_access_in,
    input  wire logic                   fs_comm_error,
    input  wire logic                   pll_locked_in,
    input  wire logic                   ext_input_active_in,
    input  wire logic                   main_in_normal,
    input  wire logic                   wake1_event,
    input  wire logic                   wake2_event,
    input  wire logic                   pulldown_auto,
    input  wire logic [5:0]             tsd_event,
    input  wire logic [5:0]             otp_tsd_reaction,
    input  wire logic [1:0]             otp_boost_slew,
    input  wire logic [1:0]             otp_highside_drive,
    input  wire logic                   fin_in,
    output logic [15:0]                 rd_data_reg,
    output logic                        rd_valid_reg,
    output logic                        comm_error_summary_reg,
    output mdc_pkg::mdc_reg_req_t       reg_req_reg,
    output logic                        standby_request_reg,
    output logic                        ext_input_select_request_reg,
    output logic                        ext_input_select_disable_reg,
    output logic                        wakeup_reg,
    output logic                        pre_reg_pulldown_en_reg,
    output logic [1:0]                  boost_slew_rate_reg,
    output logic [5:0]                  tsd_reaction_reg,
    output logic [1:0]                  pre_reg_lowside_drive_reg,
    output logic [1:0]                  pre_reg_highside_drive_reg,
    output logic [5:0]                  tsd_shutdown_reg,
    output logic                        deep_failsafe_reg,
    output logic                        divider_ratio_reg,
    output logic [4:0]                  analog_mux_channel_reg,
    output mdc_pkg::mdc_clock_cfg_t     clock_cfg_reg,
    output logic                        fin_divided_reg
);
    import mdc_pkg::*;

    // ----------------------------------------
    // stored state
    // ----------------------------------------
    logic [4:0]  flags_reg;
    logic [4:0]  flags_next;
    logic        pll_locked_reg;
    logic        ext_active_reg;
    logic        normal_status_reg;
    logic        wake1_disable_reg;
    logic        wake2_disable_reg;
    logic        pulldown_disable_reg;
    logic        fin_prev_reg;
    logic [1:0]  fin_count_reg;
    logic        fin_half_reg;

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    wire        wr       = acc.valid && acc.write;
    wire        rd       = acc.valid && !acc.write;
    wire        addr_ok  = acc.addr <= `MDC_ADDR_CLOCK;
    wire        init_wr  = wr && acc.addr == `MDC_ADDR_TSDSLEW && normal_status_reg;
    wire        bad_acc  = acc.valid && (!addr_ok || init_wr);
    wire        wr_ok    = wr && addr_ok && !init_wr;
    wire        wr_flags = wr_ok && acc.addr == `MDC_ADDR_FLAGS;
    wire        wr_mode  = wr_ok && acc.addr == `MDC_ADDR_MODE;
    wire        wr_req   = wr_ok && acc.addr == `MDC_ADDR_REGREQ;
    wire        wr_ts    = wr_ok && acc.addr == `MDC_ADDR_TSDSLEW;
    wire        wr_mux   = wr_ok && acc.addr == `MDC_ADDR_MUXSEL;
    wire        wr_clock = wr_ok && acc.addr == `MDC_ADDR_CLOCK;
    wire [15:0] wd       = acc.wdata;

    // ----------------------------------------
    // error flag events
    // ----------------------------------------
    wire clk_miscount = spi_frame_end && spi_clk_count != `MDC_SPI_CLOCKS;
    wire spi_viol     = spi_wrong_access_in || (bad_acc && acc.src == MDC_SRC_SPI);
    wire i2c_viol     = i2c_wrong_access_in || (bad_acc && acc.src == MDC_SRC_I2C);
    wire [4:0] flag_set = {spi_clk_err_in || clk_miscount, spi_viol,
                           spi_crc_err_in, i2c_crc_err_in, i2c_viol};
    wire [4:0] flag_clr = wr_flags ? wd[`MDC_FLG_SPI_CLK:`MDC_FLG_I2C_VIOL] : 5'h00;

    // set beats a clear in the same cycle
    assign flags_next = flag_set | (flags_reg & ~flag_clr);
    wire   summary    = |flags_next || fs_comm_error;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (acc.addr)
            `MDC_ADDR_FLAGS: begin
                rd_mux[`MDC_FLG_SPI_CLK:`MDC_FLG_I2C_VIOL] = flags_reg;
                rd_mux[`MDC_FLG_SUMMARY] = |flags_reg || fs_comm_error;
            end
            `MDC_ADDR_MODE: begin
                rd_mux[`MDC_MODE_PLL_LOCK] = pll_locked_reg;
                rd_mux[`MDC_MODE_EXT_ACT]  = ext_active_reg;
                rd_mux[`MDC_MODE_NORMAL]   = normal_status_reg;
                rd_mux[`MDC_MODE_WAKE2]    = wake2_disable_reg;
                rd_mux[`MDC_MODE_WAKE1]    = wake1_disable_reg;
            end
            `MDC_ADDR_REGREQ: begin
                // request bits are not stored and read zero
                rd_mux[`MDC_REQ_PD_DIS] = pulldown_disable_reg;
            end
            `MDC_ADDR_TSDSLEW: begin
                rd_mux[`MDC_TS_SLEW_MSB:`MDC_TS_SLEW_LSB]   = boost_slew_rate_reg;
                rd_mux[`MDC_TS_REACT_MSB:`MDC_TS_REACT_LSB] = tsd_reaction_reg;
                rd_mux[`MDC_TS_LS_MSB:`MDC_TS_LS_LSB]       = pre_reg_lowside_drive_reg;
                rd_mux[`MDC_TS_HS_MSB:`MDC_TS_HS_LSB]       = pre_reg_highside_drive_reg;
            end
            `MDC_ADDR_MUXSEL: begin
                rd_mux[`MDC_MUX_RATIO]  = divider_ratio_reg;
                rd_mux[4:0]             = analog_mux_channel_reg;
            end
            `MDC_ADDR_CLOCK: begin
                rd_mux[15:7] = {clock_cfg_reg.mod_range, clock_cfg_reg.out_mux,
                                clock_cfg_reg.out_phase, clock_cfg_reg.out_src};
                rd_mux[5:0]  = {clock_cfg_reg.fin_divider, clock_cfg_reg.modulation_enable,
                                clock_cfg_reg.tune};
            end
            default: rd_mux = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // flags, status and read answer
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_reg              <= 5'h00;
            comm_error_summary_reg <= 1'b0;
            rd_data_reg            <= 16'h0000;
            rd_valid_reg           <= 1'b0;
            pll_locked_reg         <= 1'b0;
            ext_active_reg         <= 1'b0;
            normal_status_reg      <= 1'b1;
        end else begin
            flags_reg              <= flags_next;
            comm_error_summary_reg <= summary;
            rd_data_reg            <= rd ? rd_mux : 16'h0000;
            rd_valid_reg           <= rd;
            pll_locked_reg         <= pll_locked_in;
            ext_active_reg         <= ext_input_active_in;
            normal_status_reg      <= main_in_normal;
        end
    end

    // ----------------------------------------
    // mode register and one-shot requests
    // ----------------------------------------
    wire req_off_any = wr_req && |wd[`MDC_REQ_OFF_MSB:`MDC_REQ_OFF_LSB];

    always_ff @(posedge mclk) begin
        if (srst) begin
            wake1_disable_reg            <= 1'b0;
            wake2_disable_reg            <= 1'b0;
            standby_request_reg          <= 1'b0;
            ext_input_select_disable_reg <= 1'b0;
            ext_input_select_request_reg <= 1'b0;
            wakeup_reg                   <= 1'b0;
            reg_req_reg                  <= '0;
        end else begin
            if (wr_mode) begin
                wake1_disable_reg <= wd[`MDC_MODE_WAKE1];
                wake2_disable_reg <= wd[`MDC_MODE_WAKE2];
            end
            standby_request_reg          <= wr_mode && wd[`MDC_MODE_STBY];
            ext_input_select_disable_reg <= wr_mode && wd[`MDC_MODE_EXT_DIS];
            ext_input_select_request_reg <= wr_clock && wd[`MDC_CLK_EXT_SEL];
            wakeup_reg <= (wake1_event && !wake1_disable_reg)
                       || (wake2_event && !wake2_disable_reg);
            reg_req_reg.off <= wr_req ? wd[`MDC_REQ_OFF_MSB:`MDC_REQ_OFF_LSB] : 7'h00;
            // a disable in the same write beats the enable
            reg_req_reg.on  <= wr_req ? wd[`MDC_REQ_ON_MSB:`MDC_REQ_ON_LSB]
                                        & ~wd[`MDC_REQ_OFF_MSB:`MDC_REQ_OFF_LSB]
                                      : 7'h00;
        end
    end

    // ----------------------------------------
    // pull-down, drive, slew and tsd reaction
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            pulldown_disable_reg       <= 1'b0;
            pre_reg_pulldown_en_reg    <= 1'b0;
            boost_slew_rate_reg        <= otp_boost_slew;
            tsd_reaction_reg           <= otp_tsd_reaction;
            pre_reg_lowside_drive_reg  <= `MDC_LS_DRIVE_RST;
            pre_reg_highside_drive_reg <= otp_highside_drive;
            tsd_shutdown_reg           <= 6'h00;
            deep_failsafe_reg          <= 1'b0;
        end else begin
            if (wr_req)
                pulldown_disable_reg <= wd[`MDC_REQ_PD_DIS];
            pre_reg_pulldown_en_reg <= pulldown_auto && !pulldown_disable_reg;
            if (wr_ts) begin
                boost_slew_rate_reg        <= wd[`MDC_TS_SLEW_MSB:`MDC_TS_SLEW_LSB];
                tsd_reaction_reg           <= wd[`MDC_TS_REACT_MSB:`MDC_TS_REACT_LSB];
                pre_reg_lowside_drive_reg  <= wd[`MDC_TS_LS_MSB:`MDC_TS_LS_LSB];
                pre_reg_highside_drive_reg <= wd[`MDC_TS_HS_MSB:`MDC_TS_HS_LSB];
            end
            tsd_shutdown_reg  <= tsd_event;
            deep_failsafe_reg <= |(tsd_event & tsd_reaction_reg);
        end
    end

    // ----------------------------------------
    // analog mux and clock configuration
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            divider_ratio_reg      <= 1'b0;
            analog_mux_channel_reg <= 5'h00;
            clock_cfg_reg          <= '0;
        end else begin
            if (wr_mux) begin
                divider_ratio_reg      <= wd[`MDC_MUX_RATIO];
                analog_mux_channel_reg <= wd[4:0];
            end
            if (wr_clock)
                clock_cfg_reg <= '{mod_range: wd[15], out_mux: wd[14:11], out_phase: wd[10:8],
                                   out_src: wd[7], fin_divider: wd[5], modulation_enable: wd[4],
                                   tune: wd[3:0]};
        end
    end

    // ----------------------------------------
    // external input divider
    // ----------------------------------------
    wire fin_rise = fin_in && !fin_prev_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            fin_prev_reg    <= 1'b0;
            fin_count_reg   <= 2'h0;
            fin_half_reg    <= 1'b0;
            fin_divided_reg <= 1'b0;
        end else begin
            fin_prev_reg <= fin_in;
            // toggle every third rising edge gives divide by six
            if (fin_rise) begin
                fin_count_reg <= (fin_count_reg == `MDC_FIN_EDGE_LAST) ? 2'h0
                                                                       : fin_count_reg + 2'h1;
                if (fin_count_reg == `MDC_FIN_EDGE_LAST)
                    fin_half_reg <= !fin_half_reg;
            end
            fin_divided_reg <= clock_cfg_reg.fin_divider ? fin_half_reg : fin_in;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence flag_write_one(int b);
        wr_flags && wd[b];
    endsequence

    clk_err_set_a: assert property (clk_miscount |=> flags_reg[`MDC_FLG_SPI_CLK])
        else $error("clock miscount did not raise flag");
    spi_viol_set_a: assert property (bad_acc && acc.src == MDC_SRC_SPI
                                     |=> flags_reg[`MDC_FLG_SPI_VIOL])
        else $error("spi violation not flagged");
    spi_crc_set_a: assert property (spi_crc_err_in |=> flags_reg[`MDC_FLG_SPI_CRC])
        else $error("spi crc error not flagged");
    i2c_crc_set_a: assert property (i2c_crc_err_in |=> flags_reg[`MDC_FLG_I2C_CRC])
        else $error("i2c crc error not flagged");
    i2c_viol_set_a: assert property (bad_acc && acc.src == MDC_SRC_I2C
                                     |=> flags_reg[`MDC_FLG_I2C_VIOL])
        else $error("i2c violation not flagged");
    flag_clear_a: assert property (flag_write_one(`MDC_FLG_SPI_CRC) ##0 !spi_crc_err_in
                                   |=> !flags_reg[`MDC_FLG_SPI_CRC])
        else $error("write one did not clear flag");
    flag_hold_a: assert property (wr_flags && !wd[`MDC_FLG_I2C_CRC] && flags_reg[`MDC_FLG_I2C_CRC]
                                  |=> flags_reg[`MDC_FLG_I2C_CRC])
        else $error("write zero changed flag");
    summary_or_a: assert property (##1 comm_error_summary_reg
                                   == (|flags_reg || $past(fs_comm_error)))
        else $error("summary bit differs from flag or");
    pll_status_a: assert property (rd && acc.addr == `MDC_ADDR_MODE
                                   |=> rd_data_reg[`MDC_MODE_PLL_LOCK]
                                       == $past(pll_locked_reg))
        else $error("pll lock status misread");
    standby_pulse_a: assert property (wr_mode && wd[`MDC_MODE_STBY]
                                      |=> standby_request_reg ##1 !standby_request_reg
                                          || $past(wr_mode, 1))
        else $error("standby request not a single pulse");
    off_request_a: assert property (req_off_any |=> |reg_req_reg.off && ~|(reg_req_reg.on
                                    & reg_req_reg.off))
        else $error("disable request lost or clashed with enable");
    tsd_deep_a: assert property (|(tsd_event & tsd_reaction_reg)
                                 |=> deep_failsafe_reg && tsd_shutdown_reg != 6'h00)
        else $error("tsd reaction did not reach deep fail-safe");
    wake_block_a: assert property (wake1_disable_reg && !wake2_event |=> !wakeup_reg)
        else $error("disabled wake input woke device");
    req_read_zero_a: assert property (rd && acc.addr == `MDC_ADDR_REGREQ
                                      |=> rd_data_reg[14:0] == 15'h0000)
        else $error("request bits read back nonzero");
    fin_pass_a: assert property (!clock_cfg_reg.fin_divider
                                 ##1 !$past(clock_cfg_reg.fin_divider)
                                 |-> fin_divided_reg == $past(fin_in))
        else $error("divide by one does not follow input");
endmodule

// *** testbench/mdc_host_model.sv ***
// host side model issuing register accesses to the bank
`timescale 1ns/100ps
module mdc_host_model (
    input  wire logic            mclk,
    input  wire logic [15:0]     rd_data_reg,
    input  wire logic            rd_valid_reg,
    output mdc_pkg::mdc_access_t acc
);
    import mdc_pkg::*;
    initial acc = '0;
    // one access, held until the taking edge, answer read one cycle later
    task automatic access(input logic wr, input mdc_src_t src, input logic [2:0] a,
                          input logic [15:0] wd, output logic [15:0] rd);
        @(negedge mclk);
        acc = '{1'b1, wr, src, a, wd};
        @(negedge mclk);
        rd = rd_valid_reg ? rd_data_reg : 16'hxxxx;
        acc = '0;
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench of the main-domain control bank
`timescale 1ns/100ps
module testbench;
    import mdc_pkg::*;
    typedef struct packed {logic [2:0] a; logic [15:0] wd; logic [15:0] rd;} mdc_row_t;
    logic mclk = 1'b0, srst = 1'b1, fs_comm_error = 1'b0, fin_in = 1'b0, prev_div;
    logic pll_locked_in = 1'b0, ext_input_active_in = 1'b0, main_in_normal = 1'b1;
    logic [5:0] spi_clk_count = 6'h00, tsd_reaction_reg, tsd_shutdown_reg;
    logic [13:0] ev = 14'h0000;
    logic [24:0] seen = '0;
    logic [15:0] rd_data_reg, d;
    logic rd_valid_reg, comm_error_summary_reg, standby_request_reg, wakeup_reg;
    logic pulldown_auto = 1'b1;
    logic ext_input_select_request_reg, ext_input_select_disable_reg, deep_failsafe_reg;
    logic pre_reg_pulldown_en_reg, divider_ratio_reg, fin_divided_reg;
    logic [1:0] boost_slew_rate_reg, pre_reg_lowside_drive_reg, pre_reg_highside_drive_reg;
    logic [4:0] analog_mux_channel_reg;
    mdc_reg_req_t reg_req_reg;
    mdc_clock_cfg_t clock_cfg_reg;
    mdc_access_t acc;
    int num_errors = 0, comparisons = 0, cycles = 0, toggles = 0, t0;
    mdc_row_t rows [6] = '{{3'h1, 16'h0007, 16'h0186}, {3'h2, 16'h8000, 16'h8000},
        {3'h3, 16'hffff, 16'hff1b}, {3'h4, 16'hffff, 16'h003f}, {3'h5, 16'hffff, 16'hffbf},
        {3'h0, 16'h001f, 16'h0000}};
    logic [15:0] rst_exp [6] = '{16'h0000, 16'h0020, 16'h0000, 16'h6a1a, 16'h0000, 16'h0000};

    mdc_host_model i_host (.mclk, .rd_data_reg, .rd_valid_reg, .acc);
    mdc_regs i_dut (.mclk, .srst, .acc, .spi_clk_err_in(ev[5]), .spi_clk_count,
        .spi_frame_end(ev[4]), .spi_crc_err_in(ev[3]), .i2c_crc_err_in(ev[2]),
        .spi_wrong_access_in(ev[1]), .i2c_wrong_access_in(ev[0]), .fs_comm_error,
        .pll_locked_in, .ext_input_active_in, .main_in_normal, .wake1_event(ev[12]),
        .wake2_event(ev[13]), .pulldown_auto, .tsd_event(ev[11:6]),
        .otp_tsd_reaction(6'h2a), .otp_boost_slew(2'h1), .otp_highside_drive(2'h2), .fin_in,
        .rd_data_reg, .rd_valid_reg, .comm_error_summary_reg, .reg_req_reg,
        .standby_request_reg, .ext_input_select_request_reg, .ext_input_select_disable_reg,
        .wakeup_reg, .pre_reg_pulldown_en_reg, .boost_slew_rate_reg, .tsd_reaction_reg,
        .pre_reg_lowside_drive_reg, .pre_reg_highside_drive_reg, .tsd_shutdown_reg,
        .deep_failsafe_reg, .divider_ratio_reg, .analog_mux_channel_reg, .clock_cfg_reg,
        .fin_divided_reg);

    always #20 mclk = ~mclk;
    // ----------------------------------------
    // pulse capture, toggle count, time limit
    // ----------------------------------------
    always @(negedge mclk) begin
        seen <= seen | {reg_req_reg, standby_request_reg, ext_input_select_request_reg,
            ext_input_select_disable_reg, wakeup_reg, deep_failsafe_reg, tsd_shutdown_reg};
        prev_div <= fin_divided_reg;
        toggles <= toggles + int'(fin_divided_reg !== prev_div);
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    task check(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [15:0] wd, input mdc_src_t s);
        i_host.access(1'b1, s, a, wd, d);
    endtask
    task rd(input logic [2:0] a, input logic [15:0] exp);
        i_host.access(1'b0, MDC_SRC_SPI, a, 16'h0000, d);
        check(d, exp);
    endtask
    task strobe(input logic [13:0] v);
        @(negedge mclk);
        ev = v;
        @(negedge mclk);
        ev = 14'h0000;
    endtask
    task expect_pulses(input logic [24:0] exp);
        repeat (2) @(negedge mclk);
        #1 check(seen, exp);
        seen = '0;
    endtask
    task do_reset;
        @(negedge mclk);
        srst = 1'b1;
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        #1 seen = '0;
    endtask
    task results;
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        do_reset();
        {main_in_normal, pll_locked_in, ext_input_active_in} = 3'b011;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd, MDC_SRC_SPI);
            rd(rows[i].a, rows[i].rd);
        end
        check({boost_slew_rate_reg, tsd_reaction_reg, pre_reg_lowside_drive_reg,
            pre_reg_highside_drive_reg, divider_ratio_reg, analog_mux_channel_reg,
            clock_cfg_reg}, 40'h01ffffffff);
        check(pre_reg_pulldown_en_reg, 0);
        {main_in_normal, pll_locked_in, ext_input_active_in} = 3'b100;
        do_reset();
        foreach (rst_exp[i]) rd(3'(i), rst_exp[i]);
        check(pre_reg_pulldown_en_reg, 1);
        pulldown_auto = 1'b0;
        @(negedge mclk) check(pre_reg_pulldown_en_reg, 0);
        pulldown_auto = 1'b1;
        wr(3'h6, 16'hffff, MDC_SRC_SPI);
        wr(3'h3, 16'h0000, MDC_SRC_I2C);
        rd(3'h3, 16'h6a1a);
        rd(3'h7, 16'h0000);
        rd(3'h0, 16'h8009);
        wr(3'h0, 16'h0009, MDC_SRC_SPI);
        main_in_normal = 1'b0;
        rd(3'h1, 16'h0000);
        spi_clk_count = 6'd31;
        strobe(14'h001f);
        rd(3'h0, 16'h801f);
        check(comm_error_summary_reg, 1);
        wr(3'h0, 16'h0004, MDC_SRC_SPI);
        rd(3'h0, 16'h801b);
        wr(3'h0, 16'h001b, MDC_SRC_I2C);
        spi_clk_count = 6'd32;
        strobe(14'h0010);
        rd(3'h0, 16'h0000);
        check(comm_error_summary_reg, 0);
        strobe(14'h0020);
        rd(3'h0, 16'h8010);
        wr(3'h0, 16'h0010, MDC_SRC_SPI);
        fs_comm_error = 1'b1;
        rd(3'h0, 16'h8000);
        fs_comm_error = 1'b0;
        wr(3'h1, 16'h0041, MDC_SRC_SPI);
        expect_pulses(25'h0000500);
        rd(3'h1, 16'h0000);
        wr(3'h1, 16'h0004, MDC_SRC_SPI);
        strobe(14'h1000);
        expect_pulses(25'h0000080);
        strobe(14'h2000);
        expect_pulses(25'h0000000);
        wr(3'h1, 16'h0002, MDC_SRC_SPI);
        strobe(14'h1000);
        expect_pulses(25'h0000000);
        strobe(14'h2000);
        expect_pulses(25'h0000080);
        wr(3'h2, 16'h7fff, MDC_SRC_SPI);
        expect_pulses(25'h003f800);
        wr(3'h2, 16'h007f, MDC_SRC_I2C);
        expect_pulses(25'h1fc0000);
        rd(3'h2, 16'h0000);
        strobe(14'h0040);
        expect_pulses(25'h0000001);
        strobe(14'h0800);
        expect_pulses(25'h0000060);
        wr(3'h5, 16'h0040, MDC_SRC_SPI);
        expect_pulses(25'h0000200);
        rd(3'h5, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            wr(3'h5, k ? 16'h0000 : 16'h0020, MDC_SRC_SPI);
            t0 = toggles;
            repeat (48) @(negedge mclk) fin_in = ~fin_in;
            repeat (4) @(negedge mclk);
            check(toggles - t0, k ? 48 : 8);
        end
        results();
    end
endmodule
